// >>> src/fnod_top.sv
// fault notification, output disable and enable watchdog logic
//
// What this block does
// - tristate indicator is monitor latch OR disable pin; it floats both drive outputs
// - monitor driving outputs from normal into tristate raises a class A event
// - disable pin tristate raises class A only while suppress bit is clear
// - tristate indicator set always sets the sticky tristate error bit
// - disable pin low runs, high tristates; its falling edge clears monitor latch
// - sampled disable pin level is readable as a status bit
// - a monitor error sets the monitor tristate latch
// - monitor inhibit bit blocks all monitor tristate and class A events
// - both fault outputs and the reset/ready output are active low
// - class A moving state 4 to 3 or 6 to 5 asserts fault A
// - fault A also asserts on enabled rises of tristate error or monitor latch
// - with both direct enables clear, fault A needs a state transition
// - class B moving to state 1 asserts fault B; otherwise only error bit and emergency-off request
// - with overvoltage-3 demote set, that event only sets its error bit
// - clear primary drops both faults and primary bits; clear secondary its bits
// - clear secondary while in state 1 requests a move to state 0
// - enable invalid-to-valid drops both faults only in state 3 or 5
// - driven fault levels and read-back pin levels are separate status bits
// - host drives a valid enable; any valid-to-invalid change raises class A
// - level mode: enable valid when high, falling edge raises class A
// - clock mode: valid after two consecutive good half-periods
// - edges restart a clk/8 counter; edge before 2 or after 6 raises class A
// - enable pin level and validity are readable status bits
`timescale 1ns/1ps
`include "fnod_defines.svh"

module fnod_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [`FNOD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins and monitor
  input wire logic output_disable_pin,
  input wire logic stage_monitor_error,
  input wire logic enable_input,
  input wire logic fault_a_pin_readback,
  input wire logic fault_b_pin_readback,
  // operating state machine
  input wire fnod_pkg::fnod_op_state_t operating_state,
  input wire logic class_b_event,
  input wire logic overvolt3_event,
  output fnod_pkg::fnod_req_t state_req,
  // outputs to the pins
  output logic drive_enable,
  output logic fault_a_n,
  output logic fault_b_n,
  output logic reset_ready_n
);

  fnod_pkg::fnod_cfg_t cfg_q;
  fnod_pkg::fnod_err_t err_q;
  fnod_pkg::fnod_req_t req_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic disable_level_q;
  logic latch_q;
  logic tristate_q;
  logic fault_a_n_q;
  logic fault_b_n_q;
  logic enable_level_q;
  logic enable_valid_q;
  logic [2:0] presc_q;
  logic [2:0] win_q;
  logic [1:0] good_q;
  logic rdy_q;
  logic tristate_err_prev_q;

  // bus access completes at the edge where waitrequest is seen low
  logic wr_ok;
  logic clr_primary;
  logic clr_secondary;
  assign wr_ok = avs_write & ~wait_q;
  assign clr_primary = wr_ok & (avs_address == `FNOD_CTRL_OFS)
    & avs_writedata[`FNOD_CTRL_CLEAR_PRIMARY_BIT];
  assign clr_secondary = wr_ok & (avs_address == `FNOD_CTRL_OFS)
    & avs_writedata[`FNOD_CTRL_CLEAR_SECONDARY_BIT];

  // one wait state per access keeps read data a clean register output
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wait_q <= 1'b1;
    else if ((avs_read | avs_write) & wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  logic [31:0] status_word;
  assign status_word = {23'h000000, fault_b_pin_readback, fault_a_pin_readback,
    fault_b_n_q, fault_a_n_q, enable_valid_q, enable_level_q,
    disable_level_q, latch_q, tristate_q};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 32'h00000000;
    else if (avs_read & wait_q)
    begin
      unique case (avs_address)
        `FNOD_CFG_OFS: rdata_q <= {26'h0000000, cfg_q};
        `FNOD_STAT_OFS: rdata_q <= status_word;
        `FNOD_ERR_OFS: rdata_q <= {27'h0000000, err_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_q <= `FNOD_CFG_RESET;
    else if (wr_ok && avs_address == `FNOD_CFG_OFS)
      cfg_q <= avs_writedata[`FNOD_CFG_W-1:0];
  end

  // output disable path
  logic pin_rise;
  logic pin_fall;
  logic mon_set;
  logic tri_event;
  assign pin_rise = output_disable_pin & ~disable_level_q;
  assign pin_fall = ~output_disable_pin & disable_level_q;
  assign mon_set = stage_monitor_error & ~cfg_q.monitor_inhibit;
  // only a change from normal drive counts as a tristate event
  assign tri_event = ~tristate_q & ((mon_set & ~latch_q)
    | (pin_rise & ~latch_q & ~cfg_q.disable_event_suppress));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      disable_level_q <= 1'b0;
    else
      disable_level_q <= output_disable_pin;
  end

  // a monitor error in the same cycle as the pin falling keeps the latch set
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      latch_q <= 1'b0;
    else if (mon_set)
      latch_q <= 1'b1;
    else if (pin_fall)
      latch_q <= 1'b0;
  end

  logic tristate_d;
  assign tristate_d = (latch_q | mon_set) & ~(pin_fall & ~mon_set) | output_disable_pin;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tristate_q <= 1'b0;
      drive_enable <= 1'b0;
    end
    else
    begin
      tristate_q <= tristate_d;
      drive_enable <= ~tristate_d;
    end
  end

  // enable input watchdog
  logic en_edge;
  logic win_bad;
  logic en_viol;
  logic en_valid_d;
  assign en_edge = enable_input ^ enable_level_q;
  assign win_bad = en_edge ? (win_q < `FNOD_WIN_LO || win_q > `FNOD_WIN_HI)
    : (win_q == `FNOD_CNT_MAX);
  assign en_valid_d = cfg_q.freq_enable_select
    ? (en_edge ? (!win_bad && good_q >= `FNOD_VALID_HALVES)
      : (enable_valid_q && !win_bad))
    : enable_input;
  assign en_viol = enable_valid_q & ~en_valid_d;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      presc_q <= 3'h0;
    else if (en_edge || presc_q == 3'(`FNOD_PRESCALE - 1))
      presc_q <= 3'h0;
    else
      presc_q <= presc_q + 3'h1;
  end

  // counter saturates at its top state, which marks a late edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      win_q <= 3'h0;
    else if (en_edge)
      win_q <= 3'h0;
    else if (presc_q == 3'(`FNOD_PRESCALE - 1) && win_q != `FNOD_CNT_MAX)
      win_q <= win_q + 3'h1;
  end

  // good_q counts edges of the current good run; the first only opens a window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      good_q <= 2'h0;
    else if (!cfg_q.freq_enable_select || (!en_edge && win_bad))
      good_q <= 2'h0;
    else if (en_edge)
      good_q <= (win_bad || good_q == 2'h0) ? 2'h1
        : (good_q == 2'h3 ? 2'h3 : good_q + 2'h1);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_level_q <= 1'b0;
      enable_valid_q <= 1'b0;
    end
    else
    begin
      enable_level_q <= enable_input;
      enable_valid_q <= en_valid_d;
    end
  end

  // class A and class B bookkeeping
  logic class_a;
  logic class_b;
  logic a_moves;
  logic b_moves;
  logic ov_b;
  logic tri_err_rise;
  logic en_restore;
  assign class_a = tri_event | en_viol;
  assign a_moves = operating_state == fnod_pkg::OP_STATE4
    || operating_state == fnod_pkg::OP_STATE6;
  assign ov_b = overvolt3_event & ~cfg_q.overvolt3_demote;
  assign class_b = class_b_event | ov_b;
  assign b_moves = operating_state != fnod_pkg::OP_STATE1
    && operating_state != fnod_pkg::OP_STATE0;
  assign tri_err_rise = tristate_q & ~tristate_err_prev_q;
  assign en_restore = ~enable_valid_q & en_valid_d
    & (operating_state == fnod_pkg::OP_STATE3 || operating_state == fnod_pkg::OP_STATE5);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tristate_err_prev_q <= 1'b0;
    else
      tristate_err_prev_q <= err_q.primary_tristate_error | tri_err_rise;
  end

  // set beats clear on every sticky bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      err_q <= '0;
    else
    begin
      err_q.tristate_sticky_error <= tristate_q | (err_q.tristate_sticky_error & ~clr_secondary);
      err_q.overvolt3_error <= overvolt3_event | (err_q.overvolt3_error & ~clr_secondary);
      err_q.class_b_error <= class_b | (err_q.class_b_error & ~clr_secondary);
      err_q.primary_tristate_error <= tristate_q
        | (err_q.primary_tristate_error & ~clr_primary);
      err_q.enable_error <= en_viol | (err_q.enable_error & ~clr_primary);
    end
  end

  logic fa_set;
  logic fb_set;
  assign fa_set = (class_a & a_moves)
    | (cfg_q.tristate_fault_a_enable & tri_err_rise)
    | (cfg_q.monitor_fault_a_enable & mon_set & ~latch_q);
  assign fb_set = class_b & b_moves;

  // faults hold until cleared; a fresh cause in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_a_n_q <= 1'b1;
      fault_b_n_q <= 1'b1;
    end
    else
    begin
      fault_a_n_q <= ~(fa_set | (~fault_a_n_q & ~clr_primary & ~en_restore));
      fault_b_n_q <= ~(fb_set | (~fault_b_n_q & ~clr_primary & ~en_restore));
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_q <= '0;
      rdy_q <= 1'b0;
    end
    else
    begin
      req_q.class_a <= class_a;
      req_q.class_b <= class_b & b_moves;
      req_q.emergency_off <= class_b;
      req_q.goto_state0 <= clr_secondary && operating_state == fnod_pkg::OP_STATE1;
      rdy_q <= 1'b1;
    end
  end

  assign fault_a_n = fault_a_n_q;
  assign fault_b_n = fault_b_n_q;
  assign reset_ready_n = rdy_q;
  assign state_req = req_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence pin_falls_s;
    disable_level_q && !output_disable_pin;
  endsequence
  sequence no_monitor_s;
    !mon_set;
  endsequence

  latch_clear_a: assert property (pin_falls_s ##0 no_monitor_s |=> !latch_q)
    else $error("monitor latch not cleared by pin fall");
  indicator_or_a: assert property (tristate_q == (latch_q || disable_level_q))
    else $error("tristate indicator wrong");
  drive_float_a: assert property (tristate_q |-> !drive_enable)
    else $error("outputs driven while tristate");
  sticky_set_a: assert property (tristate_q |=> err_q.tristate_sticky_error)
    else $error("sticky tristate error missed");
  inhibit_blocks_a: assert property (cfg_q.monitor_inhibit && !output_disable_pin
    && !latch_q |=> !latch_q)
    else $error("inhibited monitor set the latch");
  suppress_quiet_a: assert property (cfg_q.disable_event_suppress && pin_rise
    && !mon_set && !en_viol |=> !req_q.class_a)
    else $error("suppressed pin raised class A");
  fault_hold_a: assert property (!fault_a_n && !clr_primary && !en_restore
    |=> !fault_a_n)
    else $error("fault A dropped without clear");
  clear_both_a: assert property (clr_primary && !fa_set && !fb_set
    |=> fault_a_n && fault_b_n)
    else $error("clear primary left a fault");
  demote_quiet_a: assert property (cfg_q.overvolt3_demote && overvolt3_event
    && !class_b_event |=> !req_q.class_b ##0 err_q.overvolt3_error)
    else $error("demoted overvoltage caused transition");
  state0_req_a: assert property (clr_secondary && operating_state == fnod_pkg::OP_STATE1
    |=> state_req.goto_state0)
    else $error("no state 0 request");
  level_valid_a: assert property (!cfg_q.freq_enable_select && enable_valid_q
    && !enable_input |=> req_q.class_a && !enable_valid_q)
    else $error("enable fall not flagged");

endmodule

// >>> pkg/fnod_defines.svh
// offsets, field positions, reset values and timing counts of the fault/disable block
`ifndef FNOD_DEFINES_SVH
`define FNOD_DEFINES_SVH

`define FNOD_ADDR_W 4
`define FNOD_CTRL_OFS 4'h0
`define FNOD_CFG_OFS 4'h4
`define FNOD_STAT_OFS 4'h8
`define FNOD_ERR_OFS 4'hc

`define FNOD_CTRL_CLEAR_PRIMARY_BIT 0
`define FNOD_CTRL_CLEAR_SECONDARY_BIT 1
`define FNOD_CFG_W 6
`define FNOD_CFG_RESET 6'h00

`define FNOD_PRESCALE 8
`define FNOD_WIN_LO 3'h2
`define FNOD_WIN_HI 3'h6
`define FNOD_CNT_MAX 3'h7
`define FNOD_VALID_HALVES 2'h2

`endif

// >>> pkg/fnod_pkg.sv
// types shared by the fault notification and output disable block
package fnod_pkg;

  // current operating state reported by the state machine outside
  typedef enum logic [2:0] {
    OP_STATE0 = 3'h0,
    OP_STATE1 = 3'h1,
    OP_STATE2 = 3'h2,
    OP_STATE3 = 3'h3,
    OP_STATE4 = 3'h4,
    OP_STATE5 = 3'h5,
    OP_STATE6 = 3'h6
  } fnod_op_state_t;

  // configuration register, bit 5 first
  typedef struct packed {
    logic freq_enable_select;
    logic monitor_fault_a_enable;
    logic tristate_fault_a_enable;
    logic overvolt3_demote;
    logic monitor_inhibit;
    logic disable_event_suppress;
  } fnod_cfg_t;

  // sticky error bits
  typedef struct packed {
    logic enable_error;
    logic primary_tristate_error;
    logic class_b_error;
    logic overvolt3_error;
    logic tristate_sticky_error;
  } fnod_err_t;

  // requests toward the operating state machine
  typedef struct packed {
    logic class_a;
    logic class_b;
    logic emergency_off;
    logic goto_state0;
  } fnod_req_t;

endpackage

// >>> verif/fnod_host_model.sv
// host model: drives the enable pin, pulls the fault lines up
`timescale 1ns/1ps
module fnod_host_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic clock_mode,
  input wire logic level,
  input wire logic [7:0] half_len,
  // device pins
  input wire logic fault_a_n,
  input wire logic fault_b_n,
  output logic enable_input,
  output logic fault_a_pin_readback,
  output logic fault_b_pin_readback
);
  logic [7:0] cnt_q = 8'h00;
  // pulled-up lines read back what the device drives
  assign fault_a_pin_readback = fault_a_n;
  assign fault_b_pin_readback = fault_b_n;
  // half_len of zero holds the clock still
  always @(posedge clk)
  begin
    cnt_q <= (cnt_q + 8'h01 < half_len) ? cnt_q + 8'h01 : 8'h00;
    if (!clock_mode)
      enable_input <= level;
    else if (half_len != 8'h00 && cnt_q + 8'h01 >= half_len)
      enable_input <= ~enable_input;
  end
endmodule

// >>> verif/test_fault_notify_output_disable.sv
// scenario bench for the fault notification and output disable block
`timescale 1ns/1ps
`include "fnod_defines.svh"
module test_fault_notify_output_disable;
  localparam logic [3:0] CT = `FNOD_CTRL_OFS;
  localparam logic [3:0] CF = `FNOD_CFG_OFS;
  localparam logic [3:0] ST = `FNOD_STAT_OFS;
  localparam logic [3:0] ER = `FNOD_ERR_OFS;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic odp, sme, en, fa_rb, fb_rb, cbe, ove, drv, fa_n, fb_n, rr_n, cmode, level;
  logic [7:0] half;
  fnod_pkg::fnod_op_state_t opst;
  fnod_pkg::fnod_req_t req;
  int mismatches = 0;
  int n_compared = 0;
  int n_a = 0;
  int n_b = 0;
  int n_e = 0;
  int n_g = 0;
  int c;
  fnod_top dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .output_disable_pin(odp), .stage_monitor_error(sme), .enable_input(en),
    .fault_a_pin_readback(fa_rb), .fault_b_pin_readback(fb_rb),
    .operating_state(opst), .class_b_event(cbe), .overvolt3_event(ove),
    .state_req(req), .drive_enable(drv), .fault_a_n(fa_n), .fault_b_n(fb_n),
    .reset_ready_n(rr_n));
  fnod_host_model host_u (.clk(clk), .clock_mode(cmode), .level(level),
    .half_len(half), .fault_a_n(fa_n), .fault_b_n(fb_n), .enable_input(en),
    .fault_a_pin_readback(fa_rb), .fault_b_pin_readback(fb_rb));
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // requests last one cycle, so scenarios compare tallies
  always @(posedge clk)
  begin
    if (req.class_a === 1'h1) n_a++;
    if (req.class_b === 1'h1) n_b++;
    if (req.emergency_off === 1'h1) n_e++;
    if (req.goto_state0 === 1'h1) n_g++;
  end
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // entered just after an edge; holds the request until waitrequest is low,
  // then lets one idle edge pass so a following call never re-drives at once
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge clk);
    v = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask
  task automatic clr();
    bus(1'h1, CT, 32'h3);
  endtask
  task automatic t_regs();
    bus(1'h0, CF, 32'h0);
    chk_w(v, 32'h0);
    bus(1'h1, CF, 32'h3f);
    bus(1'h0, CF, 32'h0);
    chk_w(v, 32'h3f);
    bus(1'h0, 4'h2, 32'h0);
    chk_w(v, 32'h0);
    chk_b(rr_n, 1'h1);
    chk_b(fa_n, 1'h1);
  endtask
  task automatic t_disable();
    bus(1'h1, CF, 32'h0);
    clr();
    c = n_a;
    odp <= 1'h1;
    tick(3);
    chk_b(drv, 1'h0);
    chk_w(32'(n_a - c), 32'h1);
    chk_b(fa_n, 1'h1);
    bus(1'h0, ST, 32'h0);
    chk_w(v & 32'h7, 32'h5);
    bus(1'h0, ER, 32'h0);
    chk_w(v & 32'h9, 32'h9);
    odp <= 1'h0;
    tick(3);
    chk_b(drv, 1'h1);
    bus(1'h1, CF, 32'h1);
    clr();
    c = n_a;
    odp <= 1'h1;
    tick(3);
    chk_w(32'(n_a - c), 32'h0);
    chk_b(drv, 1'h0);
    bus(1'h0, ER, 32'h0);
    chk_w(v & 32'h1, 32'h1);
    odp <= 1'h0;
    tick(2);
  endtask
  task automatic t_monitor();
    bus(1'h1, CF, 32'h0);
    clr();
    c = n_a;
    sme <= 1'h1;
    tick(1);
    sme <= 1'h0;
    tick(3);
    chk_b(drv, 1'h0);
    chk_w(32'(n_a - c), 32'h1);
    bus(1'h0, ST, 32'h0);
    chk_w(v & 32'h3, 32'h3);
    odp <= 1'h1;
    tick(2);
    odp <= 1'h0;
    tick(3);
    chk_b(drv, 1'h1);
    bus(1'h1, CF, 32'h2);
    c = n_a;
    sme <= 1'h1;
    tick(3);
    sme <= 1'h0;
    chk_b(drv, 1'h1);
    chk_w(32'(n_a - c), 32'h0);
  endtask
  task automatic t_fault_a();
    bus(1'h1, CF, 32'h0);
    clr();
    opst <= fnod_pkg::OP_STATE4;
    odp <= 1'h1;
    tick(3);
    odp <= 1'h0;
    tick(5);
    chk_b(fa_n, 1'h0);
    bus(1'h0, ST, 32'h0);
    chk_w(v & 32'h1e0, 32'h140);
    clr();
    tick(2);
    chk_b(fa_n, 1'h1);
    opst <= fnod_pkg::OP_STATE0;
    bus(1'h1, CF, 32'h8);
    clr();
    odp <= 1'h1;
    tick(4);
    chk_b(fa_n, 1'h0);
    odp <= 1'h0;
    tick(2);
    bus(1'h1, CF, 32'h10);
    clr();
    sme <= 1'h1;
    tick(1);
    sme <= 1'h0;
    tick(3);
    chk_b(fa_n, 1'h0);
    odp <= 1'h1;
    tick(2);
    odp <= 1'h0;
    tick(2);
  endtask
  task automatic t_enable();
    bus(1'h1, CF, 32'h0);
    clr();
    opst <= fnod_pkg::OP_STATE4;
    c = n_a;
    level <= 1'h0;
    tick(4);
    chk_w(32'(n_a - c), 32'h1);
    chk_b(fa_n, 1'h0);
    bus(1'h0, ST, 32'h0);
    chk_w(v & 32'h18, 32'h0);
    opst <= fnod_pkg::OP_STATE3;
    level <= 1'h1;
    tick(4);
    chk_b(fa_n, 1'h1);
    bus(1'h0, ST, 32'h0);
    chk_w(v & 32'h18, 32'h18);
  endtask
  task automatic t_class_b();
    clr();
    opst <= fnod_pkg::OP_STATE2;
    c = n_b;
    cbe <= 1'h1;
    tick(1);
    cbe <= 1'h0;
    tick(3);
    chk_b(fb_n, 1'h0);
    chk_w(32'(n_b - c), 32'h1);
    level <= 1'h0;
    tick(3);
    level <= 1'h1;
    tick(3);
    chk_b(fb_n, 1'h0);
    bus(1'h1, CT, 32'h2);
    tick(2);
    chk_b(fb_n, 1'h0);
    clr();
    tick(2);
    chk_b(fb_n, 1'h1);
    opst <= fnod_pkg::OP_STATE1;
    c = n_b;
    cbe <= 1'h1;
    tick(1);
    cbe <= 1'h0;
    tick(3);
    chk_b(fb_n, 1'h1);
    chk_w(32'(n_b - c), 32'h0);
    bus(1'h0, ER, 32'h0);
    chk_w(v & 32'h4, 32'h4);
    c = n_g;
    bus(1'h1, CT, 32'h2);
    tick(2);
    chk_w(32'(n_g - c), 32'h1);
    bus(1'h0, ER, 32'h0);
    chk_w(v & 32'h4, 32'h0);
    opst <= fnod_pkg::OP_STATE2;
    bus(1'h1, CF, 32'h4);
    clr();
    c = n_e;
    ove <= 1'h1;
    tick(1);
    ove <= 1'h0;
    tick(3);
    chk_b(fb_n, 1'h1);
    chk_w(32'(n_e - c), 32'h0);
    bus(1'h0, ER, 32'h0);
    chk_w(v & 32'h2, 32'h2);
  endtask
  task automatic t_clock();
    bus(1'h1, CF, 32'h20);
    cmode <= 1'h1;
    half <= 8'h20;
    tick(200);
    bus(1'h0, ST, 32'h0);
    chk_b(v[4], 1'h1);
    c = n_a;
    half <= 8'h08;
    tick(100);
    chk_w(32'(n_a - c), 32'h1);
    half <= 8'h20;
    tick(200);
    clr();
    c = n_a;
    half <= 8'h00;
    tick(100);
    chk_w(32'(n_a - c), 32'h1);
    bus(1'h0, ER, 32'h0);
    chk_w(v & 32'h10, 32'h10);
    cmode <= 1'h0;
    bus(1'h1, CF, 32'h0);
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    reset_n = 1'h0;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    odp = 1'h0;
    sme = 1'h0;
    cbe = 1'h0;
    ove = 1'h0;
    opst = fnod_pkg::OP_STATE0;
    level = 1'h1;
    cmode = 1'h0;
    half = 8'h00;
    tick(8);
    chk_b(rr_n, 1'h0);
    reset_n <= 1'h1;
    tick(2);
    t_regs();
    t_disable();
    t_monitor();
    t_fault_a();
    t_enable();
    t_class_b();
    t_clock();
    give_verdict();
  end
  initial
  begin
    #3000000;
    mismatches++;
    give_verdict();
  end
endmodule
